//--- dv/can_bus_model.sv
// Behavioural far-side model: bus activity, receive events and error counters.
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
  input  wire logic       clk,
  output logic            busActivity,
  output logic            overrunEvent,
  output logic            rxFrameStored,
  output logic      [7:0] rxErrCount,
  output logic      [8:0] txErrCount
);
  initial
  begin
    busActivity   = 1'b0;
    overrunEvent  = 1'b0;
    rxFrameStored = 1'b0;
    rxErrCount    = 8'h00;
    txErrCount    = 9'h000;
  end

  // One-cycle event, so that each call sets its flag exactly once.
  task automatic pulse(input int src);
    @(posedge clk);
    case (src)
      0: overrunEvent <= 1'b1;
      1: rxFrameStored <= 1'b1;
      default: busActivity <= 1'b1;
    endcase
    @(posedge clk);
    {busActivity, overrunEvent, rxFrameStored} <= 3'h0;
  endtask

  task automatic setCounts(input logic [7:0] rc, input logic [8:0] tc);
    @(posedge clk);
    rxErrCount <= rc;
    txErrCount <= tc;
  endtask
endmodule
`default_nettype wire

//--- dv/can_rx_irq_enable_tb.sv
// Self-checking testbench of the receiver interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
module can_rx_irq_enable_tb;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busActivity;
  logic        overrunEvent;
  logic        rxFrameStored;
  logic [7:0]  rxErrCount;
  logic [8:0]  txErrCount;
  logic        wakeIrq;
  logic        errorIrq;
  logic        rxIrq;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  localparam logic [7:0] EN = can_rx_irq_pkg::ENABLE_ADDR;
  localparam logic [7:0] FL = can_rx_irq_pkg::FLAG_ADDR;
  localparam logic [7:0] CT = can_rx_irq_pkg::CTRL_ADDR;

  always #2.5 clk = ~clk;

  can_rx_irq_enable dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busActivity(busActivity), .overrunEvent(overrunEvent),
    .rxFrameStored(rxFrameStored), .rxErrCount(rxErrCount), .txErrCount(txErrCount),
    .wakeIrq(wakeIrq), .errorIrq(errorIrq), .rxIrq(rxIrq));

  can_bus_model bus (.clk(clk), .busActivity(busActivity), .overrunEvent(overrunEvent),
    .rxFrameStored(rxFrameStored), .rxErrCount(rxErrCount), .txErrCount(txErrCount));

  // ---------------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // The master never assumes the wait-state count; only the bound ends a hang.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
      chk("pready", 32'h1, {31'h0, pready});
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask

  task automatic rdChk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(what, exp, rd);
  endtask

  function automatic logic irqOf(input int b);
    return b == 7 ? wakeIrq : (b == 1 ? errorIrq : rxIrq);
  endfunction

  task automatic stepSt(input logic [7:0] rc, input logic [8:0] tc, input logic exp);
    bus.setCounts(rc, tc);
    repeat (4) @(posedge clk);
    apb(1'b0, FL, 32'h0);
    chk("status flag", {31'h0, exp}, {31'h0, rd[6]});
    chk("error request", {31'h0, exp}, {31'h0, errorIrq});
    if (exp)
      wr(FL, 32'h40);
    repeat (3) @(posedge clk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rdChk("enables reset", EN, 32'h0);
    rdChk("flags reset", FL, 32'h0);
    rdChk("control reset", CT, 32'h0);
    rdChk("unmapped read", 8'h08, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask

  task automatic t_init;
    wr(EN, 32'hFF);
    rdChk("enables written", EN, 32'hFF);
    wr(CT, 32'h1);
    rdChk("init acknowledged", CT, 32'h3);
    rdChk("enables in init", EN, 32'h3C);
    wr(EN, 32'hC3);
    rdChk("enable write in init", EN, 32'h00);
    wr(EN, 32'h14);
    rdChk("sensitivity in init", EN, 32'h14);
    wr(CT, 32'h0);
    wr(EN, 32'hC3);
    rdChk("enables after init", EN, 32'hC3);
    $display("test init done");
  endtask

  task automatic t_event(input int b, input int src);
    wr(CT, 32'h4);
    wr(EN, 32'h0);
    bus.pulse(src);
    repeat (4) @(posedge clk);
    chk("masked request", 32'h0, {31'h0, irqOf(b)});
    rdChk("event flag", FL, 32'h1 << b);
    wr(EN, 32'h1 << b);
    repeat (2) @(posedge clk);
    chk("raised request", 32'h1, {31'h0, irqOf(b)});
    wr(EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("request off by enable", 32'h0, {31'h0, irqOf(b)});
    wr(EN, 32'h1 << b);
    wr(FL, 32'h1 << b);
    repeat (2) @(posedge clk);
    chk("request off by flag", 32'h0, {31'h0, irqOf(b)});
    $display("test event %0d done", b);
  endtask

  task automatic t_wakeGate;
    wr(CT, 32'h0);
    wr(EN, 32'h80);
    bus.pulse(2);
    repeat (4) @(posedge clk);
    chk("wake without function", 32'h0, {31'h0, wakeIrq});
    $display("test wake gate done");
  endtask

  task automatic t_rxSens;
    for (int c = 0; c < 4; c++)
    begin
      wr(EN, 32'h40 | (32'(c) << 4));
      stepSt(8'd96, 9'd0, 1'b0);
      stepSt(8'd97, 9'd0, c == 3);
      stepSt(8'd127, 9'd0, 1'b0);
      stepSt(8'd128, 9'd0, c >= 2);
      stepSt(8'd0, 9'd0, c >= 2);
      stepSt(8'd0, 9'd256, c != 0);
      stepSt(8'd0, 9'd0, c != 0);
    end
    $display("test receiver sensitivity done");
  endtask

  task automatic t_txSens;
    for (int c = 0; c < 4; c++)
    begin
      wr(EN, 32'h40 | (32'(c) << 2));
      stepSt(8'd0, 9'd96, 1'b0);
      stepSt(8'd0, 9'd97, c == 3);
      stepSt(8'd0, 9'd255, c >= 2);
      stepSt(8'd0, 9'd256, c != 0);
      stepSt(8'd0, 9'd0, c != 0);
    end
    $display("test transmitter sensitivity done");
  endtask

  task automatic t_freeze;
    wr(EN, 32'h30);
    bus.setCounts(8'd100, 9'd0);
    repeat (4) @(posedge clk);
    rdChk("state at flag", FL, 32'h50);
    chk("status masked", 32'h0, {31'h0, errorIrq});
    bus.setCounts(8'd130, 9'd0);
    repeat (4) @(posedge clk);
    rdChk("state held", FL, 32'h50);
    wr(FL, 32'h40);
    repeat (4) @(posedge clk);
    rdChk("state after clear", FL, 32'h60);
    bus.setCounts(8'd0, 9'd0);
    wr(FL, 32'h40);
    repeat (4) @(posedge clk);
    wr(FL, 32'h40);
    $display("test state freeze done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_wakeGate();
    t_event(7, 2);
    t_event(1, 0);
    t_event(0, 1);
    t_rxSens();
    t_txSens();
    t_freeze();
    tally_and_finish();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- inc/can_rx_irq_pkg.sv
// Constants, register map and state codes of the receiver interrupt enable block.
// What this block does
// - Enables are held at reset in init mode and written only if request and acknowledge are 0.
// - Init mode never resets or disturbs the rx and tx sensitivity fields.
// - Bit 7 enables the wake-up request from the wake event flag.
// - Bit 6 enables the error request from the status change flag.
// - Rx sensitivity 00 is none, 01 bus-off in or out, 10 error or bus-off in or out.
// - Tx sensitivity 00 is none, 01 bus-off in or out, 10 error or bus-off in or out, 11 all.
// - Reported bus states track the real ones, updating only while no status change pends.
// - Bit 1 enables the error request from the overrun event flag.
// - Bit 0 enables the receiver request from the receive buffer full flag.
// - A request stands while a flag and its enable are both set, and falls when no such pair is left.
// - Rx state: OK to 96, warning to 127, error above 127, bus-off when tx count exceeds 255.
package can_rx_irq_pkg;

  // ----------------------------------------------------------------------------
  // Register map: each register has an index; its byte address is four times that.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] CTRL_INDEX   = 8'h00;
  localparam logic [7:0] FLAG_INDEX   = 8'h04;
  localparam logic [7:0] ENABLE_INDEX = 8'h05;
  localparam logic [7:0] CTRL_ADDR    = 8'(CTRL_INDEX * 4);
  localparam logic [7:0] FLAG_ADDR    = 8'(FLAG_INDEX * 4);
  localparam logic [7:0] ENABLE_ADDR  = 8'(ENABLE_INDEX * 4);

  // ----------------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------------
  localparam int WAKE_BIT     = 7;
  localparam int STATUS_BIT   = 6;
  localparam int RX_SENS_LSB  = 4;
  localparam int TX_SENS_LSB  = 2;
  localparam int OVERRUN_BIT  = 1;
  localparam int RX_FULL_BIT  = 0;
  localparam int INIT_REQ_BIT = 0;
  localparam int INIT_ACK_BIT = 1;
  localparam int WAKE_FN_BIT  = 2;

  // ----------------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [1:0] SENS_RESET   = 2'h0;

  // ----------------------------------------------------------------------------
  // Bus states and sensitivity codes.
  // ----------------------------------------------------------------------------
  localparam logic [1:0] STATE_OK      = 2'h0;
  localparam logic [1:0] STATE_WARNING = 2'h1;
  localparam logic [1:0] STATE_ERROR   = 2'h2;
  localparam logic [1:0] STATE_BUS_OFF = 2'h3;
  localparam logic [1:0] SENS_NONE     = 2'h0;
  localparam logic [1:0] SENS_BUS_OFF  = 2'h1;
  localparam logic [1:0] SENS_ERROR    = 2'h2;
  localparam logic [1:0] SENS_ALL      = 2'h3;

  localparam logic [8:0] WARNING_LIMIT = 9'd96;
  localparam logic [8:0] ERROR_LIMIT   = 9'd127;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'd255;

endpackage

//--- logic/can_rx_irq_enable.sv
// Receiver interrupt enable register, event flags and request gating behind APB.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module can_rx_irq_enable (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        busActivity,
  input  wire logic        overrunEvent,
  input  wire logic        rxFrameStored,
  input  wire logic [7:0]  rxErrCount,
  input  wire logic [8:0]  txErrCount,
  output logic             wakeIrq,
  output logic             errorIrq,
  output logic             rxIrq
);

  // ----------------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------------
  logic       initModeRequest;
  logic       initModeAcknowledge;
  logic       wakeFunctionEnable;
  logic       wakeIrqEnable;
  logic       statusIrqEnable;
  logic       overrunIrqEnable;
  logic       rxFullIrqEnable;
  logic [1:0] rxSens;
  logic [1:0] txSens;
  logic       wakeEventFlag;
  logic       statusChangeFlag;
  logic       overrunEventFlag;
  logic       rxBufferFullFlag;
  logic [1:0] rxBusState;
  logic [1:0] txBusState;
  logic [1:0] rxNow;
  logic [1:0] txNow;
  logic       activityMeta;
  logic       activitySync;
  logic       apbDone;
  logic       writeStrobe;
  logic       selCtrl;
  logic       selFlag;
  logic       selEnable;
  logic       initActive;
  logic       writeOpen;
  logic       rxHit;
  logic       txHit;
  logic [7:0] enableValue;
  logic [7:0] flagValue;
  logic [31:0] next_prdata;

  // ----------------------------------------------------------------------------
  // APB slave: one wait state, then pready and registered data.
  // ----------------------------------------------------------------------------
  assign apbDone     = psel & penable & pready;
  assign writeStrobe = apbDone & pwrite;
  assign selCtrl     = paddr == can_rx_irq_pkg::CTRL_ADDR;
  assign selFlag     = paddr == can_rx_irq_pkg::FLAG_ADDR;
  assign selEnable   = paddr == can_rx_irq_pkg::ENABLE_ADDR;
  assign enableValue = {wakeIrqEnable, statusIrqEnable, rxSens, txSens,
                        overrunIrqEnable, rxFullIrqEnable};
  assign flagValue   = {wakeEventFlag, statusChangeFlag, rxBusState, txBusState,
                        overrunEventFlag, rxBufferFullFlag};

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (selCtrl)
      next_prdata = {29'h0000_0000, wakeFunctionEnable, initModeAcknowledge, initModeRequest};
    else if (selFlag)
      next_prdata = {24'h00_0000, flagValue};
    else if (selEnable)
      next_prdata = {24'h00_0000, enableValue};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {pready, pslverr, prdata} <= 34'h0_0000_0000;
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(selCtrl | selFlag | selEnable);
      prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // Control: init request with a one-cycle acknowledge, wake function enable.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      initModeRequest    <= can_rx_irq_pkg::CTRL_RESET[can_rx_irq_pkg::INIT_REQ_BIT];
      wakeFunctionEnable <= can_rx_irq_pkg::CTRL_RESET[can_rx_irq_pkg::WAKE_FN_BIT];
    end
    else if (writeStrobe && selCtrl)
    begin
      initModeRequest    <= pwdata[can_rx_irq_pkg::INIT_REQ_BIT];
      wakeFunctionEnable <= pwdata[can_rx_irq_pkg::WAKE_FN_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      initModeAcknowledge <= can_rx_irq_pkg::CTRL_RESET[can_rx_irq_pkg::INIT_ACK_BIT];
    else
      initModeAcknowledge <= initModeRequest;
  end
  assign initActive = initModeRequest & initModeAcknowledge;
  assign writeOpen  = ~initModeRequest & ~initModeAcknowledge;

  // ----------------------------------------------------------------------------
  // Enable register.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wakeIrqEnable    <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::WAKE_BIT];
      statusIrqEnable  <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::STATUS_BIT];
      overrunIrqEnable <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::OVERRUN_BIT];
      rxFullIrqEnable  <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::RX_FULL_BIT];
    end
    else if (initActive)
    begin
      wakeIrqEnable    <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::WAKE_BIT];
      statusIrqEnable  <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::STATUS_BIT];
      overrunIrqEnable <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::OVERRUN_BIT];
      rxFullIrqEnable  <= can_rx_irq_pkg::ENABLE_RESET[can_rx_irq_pkg::RX_FULL_BIT];
    end
    else if (writeStrobe && selEnable && writeOpen)
    begin
      wakeIrqEnable    <= pwdata[can_rx_irq_pkg::WAKE_BIT];
      statusIrqEnable  <= pwdata[can_rx_irq_pkg::STATUS_BIT];
      overrunIrqEnable <= pwdata[can_rx_irq_pkg::OVERRUN_BIT];
      rxFullIrqEnable  <= pwdata[can_rx_irq_pkg::RX_FULL_BIT];
    end
  end

  // Sensitivity stays writable in init mode so it can be set up before leaving it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {rxSens, txSens} <= {2{can_rx_irq_pkg::SENS_RESET}};
    else if (writeStrobe && selEnable)
    begin
      rxSens <= pwdata[can_rx_irq_pkg::RX_SENS_LSB +: 2];
      txSens <= pwdata[can_rx_irq_pkg::TX_SENS_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------------
  // Status change detection.
  // ----------------------------------------------------------------------------
  can_state_decode stateDecode (.clk(clk), .rst(rst), .rxErrCount(rxErrCount),
    .txErrCount(txErrCount), .rxState(rxNow), .txState(txNow));

  function automatic logic qualifies(input logic [1:0] sens, input logic [1:0] was,
                                     input logic [1:0] now);
    logic changed;
    changed = was != now;
    case (sens)
      can_rx_irq_pkg::SENS_BUS_OFF:
        qualifies = changed && (was == can_rx_irq_pkg::STATE_BUS_OFF
                                || now == can_rx_irq_pkg::STATE_BUS_OFF);
      can_rx_irq_pkg::SENS_ERROR:
        qualifies = changed && (was[1] || now[1]);
      can_rx_irq_pkg::SENS_ALL:
        qualifies = changed;
      default:
        qualifies = 1'b0;
    endcase
  endfunction
  assign rxHit = qualifies(rxSens, rxBusState, rxNow);
  assign txHit = qualifies(txSens, txBusState, txNow);

  // Reported states freeze while the flag is pending so software sees a
  // consistent snapshot of what caused the interrupt.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxBusState <= can_rx_irq_pkg::STATE_OK;
      txBusState <= can_rx_irq_pkg::STATE_OK;
    end
    else if (!statusChangeFlag)
    begin
      rxBusState <= rxNow;
      txBusState <= txNow;
    end
  end

  // ----------------------------------------------------------------------------
  // Event flags: write one to clear; a new wake, overrun or receive event wins over the clear, a status clear wins.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {activityMeta, activitySync} <= 2'h0;
    else
      {activityMeta, activitySync} <= {busActivity, activityMeta};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {wakeEventFlag, statusChangeFlag, overrunEventFlag, rxBufferFullFlag} <= 4'h0;
    else
    begin
      wakeEventFlag    <= (activitySync & wakeFunctionEnable)
                          | (wakeEventFlag & ~(writeStrobe & selFlag
                                               & pwdata[can_rx_irq_pkg::WAKE_BIT]));
      statusChangeFlag <= (~statusChangeFlag & (rxHit | txHit))
                          | (statusChangeFlag & ~(writeStrobe & selFlag
                                                  & pwdata[can_rx_irq_pkg::STATUS_BIT]));
      overrunEventFlag <= overrunEvent
                          | (overrunEventFlag & ~(writeStrobe & selFlag
                                                  & pwdata[can_rx_irq_pkg::OVERRUN_BIT]));
      rxBufferFullFlag <= rxFrameStored
                          | (rxBufferFullFlag & ~(writeStrobe & selFlag
                                                  & pwdata[can_rx_irq_pkg::RX_FULL_BIT]));
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt requests, level while flag and enable stand.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {wakeIrq, errorIrq, rxIrq} <= 3'h0;
    else
    begin
      wakeIrq  <= wakeEventFlag & wakeIrqEnable;
      errorIrq <= (statusChangeFlag & statusIrqEnable)
                  | (overrunEventFlag & overrunIrqEnable);
      rxIrq    <= rxBufferFullFlag & rxFullIrqEnable;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  sequence quietSens;
    rxSens == can_rx_irq_pkg::SENS_NONE && txSens == can_rx_irq_pkg::SENS_NONE
    && !statusChangeFlag;
  endsequence
  sequence txEntersBusOff;
    !statusChangeFlag && txSens != can_rx_irq_pkg::SENS_NONE
    && txBusState != can_rx_irq_pkg::STATE_BUS_OFF && txNow == can_rx_irq_pkg::STATE_BUS_OFF;
  endsequence

  init_hold_a : assert property (@(posedge clk) disable iff (rst)
    initActive |=> !wakeIrqEnable && !statusIrqEnable && !overrunIrqEnable && !rxFullIrqEnable)
    else $error("Enables not held at reset in init mode.");
  write_lands_a : assert property (@(posedge clk) disable iff (rst)
    writeStrobe && selEnable && writeOpen |=> enableValue == $past(pwdata[7:0]))
    else $error("Enable write did not land.");
  sens_keep_a : assert property (@(posedge clk) disable iff (rst)
    initActive && !(writeStrobe && selEnable) |=> $stable({rxSens, txSens}))
    else $error("Sensitivity disturbed in init mode.");
  wake_request_a : assert property (@(posedge clk) disable iff (rst)
    (wakeEventFlag && wakeIrqEnable) [*2] |-> wakeIrq)
    else $error("Wake request missing.");
  no_wake_a : assert property (@(posedge clk) disable iff (rst)
    !wakeIrqEnable |=> !wakeIrq)
    else $error("Wake request while disabled.");
  error_request_a : assert property (@(posedge clk) disable iff (rst)
    (statusChangeFlag && statusIrqEnable) || (overrunEventFlag && overrunIrqEnable)
    |=> errorIrq)
    else $error("Error request missing.");
  rx_request_a : assert property (@(posedge clk) disable iff (rst)
    rxBufferFullFlag && !rxFullIrqEnable |=> !rxIrq ##1 (rxIrq == $past(rxBufferFullFlag
                                                          && rxFullIrqEnable)))
    else $error("Receive request wrong.");
  quiet_sens_a : assert property (@(posedge clk) disable iff (rst)
    quietSens |=> !statusChangeFlag)
    else $error("Status flag set with no sensitivity.");
  bus_off_flag_a : assert property (@(posedge clk) disable iff (rst)
    txEntersBusOff |=> statusChangeFlag && txBusState == can_rx_irq_pkg::STATE_BUS_OFF)
    else $error("Bus-off entry not flagged.");
  state_freeze_a : assert property (@(posedge clk) disable iff (rst)
    statusChangeFlag |=> $stable({rxBusState, txBusState}))
    else $error("Reported state moved while flag pending.");

endmodule
`default_nettype wire

//--- logic/can_state_decode.sv
// Decoder from the error counters to the receiver and transmitter bus states.
`timescale 1ns/1ps
`default_nettype none
module can_state_decode (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] rxErrCount,
  input  wire logic [8:0] txErrCount,
  output logic      [1:0] rxState,
  output logic      [1:0] txState
);

  logic [1:0] next_rxState;
  logic [1:0] next_txState;

  // Bus-off on the transmitter forces the receiver state too.
  always_comb
  begin
    if (txErrCount > can_rx_irq_pkg::BUS_OFF_LIMIT)
      next_rxState = can_rx_irq_pkg::STATE_BUS_OFF;
    else if ({1'b0, rxErrCount} > can_rx_irq_pkg::ERROR_LIMIT)
      next_rxState = can_rx_irq_pkg::STATE_ERROR;
    else if ({1'b0, rxErrCount} > can_rx_irq_pkg::WARNING_LIMIT)
      next_rxState = can_rx_irq_pkg::STATE_WARNING;
    else
      next_rxState = can_rx_irq_pkg::STATE_OK;
  end

  always_comb
  begin
    if (txErrCount > can_rx_irq_pkg::BUS_OFF_LIMIT)
      next_txState = can_rx_irq_pkg::STATE_BUS_OFF;
    else if (txErrCount > can_rx_irq_pkg::ERROR_LIMIT)
      next_txState = can_rx_irq_pkg::STATE_ERROR;
    else if (txErrCount > can_rx_irq_pkg::WARNING_LIMIT)
      next_txState = can_rx_irq_pkg::STATE_WARNING;
    else
      next_txState = can_rx_irq_pkg::STATE_OK;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxState <= can_rx_irq_pkg::STATE_OK;
      txState <= can_rx_irq_pkg::STATE_OK;
    end
    else
    begin
      rxState <= next_rxState;
      txState <= next_txState;
    end
  end

  rx_ok_range_a : assert property (@(posedge clk) disable iff (rst)
    ({1'b0, rxErrCount} <= can_rx_irq_pkg::WARNING_LIMIT
     && txErrCount <= can_rx_irq_pkg::BUS_OFF_LIMIT) |=> rxState == can_rx_irq_pkg::STATE_OK)
    else $error("Receiver state not OK for a low count.");

  bus_off_both_a : assert property (@(posedge clk) disable iff (rst)
    txErrCount > can_rx_irq_pkg::BUS_OFF_LIMIT
    |=> rxState == can_rx_irq_pkg::STATE_BUS_OFF && txState == can_rx_irq_pkg::STATE_BUS_OFF)
    else $error("Bus-off not shown on both states.");

endmodule
`default_nettype wire
